//--- hdl/ief_pkg.sv
package ief_pkg;
    // processing time base and clock
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned TICK_PERIOD_US = 5000;
    localparam int unsigned TICK_CYCLES    = TICK_PERIOD_US * 1000
                                             / CLK_PERIOD_NS;
    // register indices (word addresses)
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_VTHR   = 4'h1;
    localparam logic [3:0] REG_ITHR   = 4'h2;
    localparam logic [3:0] REG_FWDRST = 4'h3;
    localparam logic [3:0] REG_REVRST = 4'h4;
    localparam logic [3:0] REG_OPTIME = 4'h5;
    localparam logic [3:0] REG_SPIKES = 4'h6;
    localparam logic [3:0] REG_STATUS = 4'h7;
    localparam logic [3:0] REG_EXPT   = 4'h8;
    localparam logic [3:0] REG_TREM   = 4'h9;
    localparam logic [3:0] REG_SPREM  = 4'ha;
    localparam logic [3:0] REG_FWDCNT = 4'hb;
    localparam logic [3:0] REG_REVCNT = 4'hc;
    // control field positions
    localparam int unsigned CTRL_FEN_BIT = 0;
    localparam int unsigned CTRL_FRC_LSB = 1;
    localparam int unsigned CTRL_ISL_LSB = 4;
    localparam int unsigned CTRL_VSL_LSB = 6;
    // status field positions
    localparam int unsigned STS_VCH_LSB = 4;
    localparam int unsigned STS_FWD_BIT = 8;
    localparam int unsigned STS_REV_BIT = 9;
    localparam int unsigned STS_TRP_BIT = 10;
    localparam int unsigned STS_BLK_BIT = 11;
    // reset values (thresholds in 0.01 units, times in 5 ms ticks)
    localparam logic [15:0] VTHR_RST   = 16'h1f40;
    localparam logic [15:0] ITHR_RST   = 16'h0032;
    localparam logic [18:0] FWDRST_RST = 19'h0003c;
    localparam logic [18:0] REVRST_RST = 19'h0003c;
    localparam logic [18:0] OPTIME_RST = 19'h00064;
    localparam logic [31:0] SPIKES_RST = 32'h00000002;
    localparam logic [1:0]  ISEL_RST   = 2'h1;
    localparam logic [1:0]  VSEL_RST   = 2'h1;
    // forced status codes
    localparam logic [2:0] FRC_NORMAL = 3'h0;
    localparam logic [2:0] FRC_BLOCK  = 3'h1;
    localparam logic [2:0] FRC_FWD    = 3'h2;
    localparam logic [2:0] FRC_REV    = 3'h3;
    localparam logic [2:0] FRC_TRIP   = 3'h4;
    // reported status codes
    localparam logic [2:0] STS_NORMAL = 3'h0;
    localparam logic [2:0] STS_FWD    = 3'h1;
    localparam logic [2:0] STS_REV    = 3'h2;
    localparam logic [2:0] STS_TRIP   = 3'h3;
    localparam logic [2:0] STS_BLOCK  = 3'h4;
    // one set of residual samples
    typedef struct packed {
        logic               valid;
        logic signed [15:0] volt_three;
        logic signed [15:0] volt_four;
        logic signed [15:0] cur_one;
        logic signed [15:0] cur_two;
    } ief_samp_s;
endpackage

//--- hdl/ief_stage.sv
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module ief_stage #(
    parameter int unsigned TICK_LEN = ief_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic              mclk_in,
    input  wire logic              rst_in,
    // register port
    input  wire logic [3:0]        reg_addr_in,
    input  wire logic [31:0]       reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic      [31:0]       reg_rdata_out,
    // residual samples and blocking
    input  wire ief_pkg::ief_samp_s samp_in,
    input  wire logic              block_in,
    // stage outputs
    output logic                   forward_start_out,
    output logic                   reverse_start_out,
    output logic                   trip_out,
    output logic                   blocked_out
);
    import ief_pkg::*;

    initial begin
        if (TICK_LEN < 2) begin
            $error("tick length too short");
        end
    end

    // whole state of the stage
    typedef struct packed {
        logic [31:0]        tick_cnt;   // strobe divider
        logic signed [15:0] vpk;        // voltage peak of this buffer
        logic signed [15:0] ipk;        // current peak of this buffer
        logic               force_en;
        logic [2:0]         force_code;
        logic [1:0]         in_sel;
        logic [1:0]         volt_sel;
        logic [15:0]        vthr;
        logic [15:0]        ithr;
        logic [18:0]        fwd_set;
        logic [18:0]        rev_set;
        logic [18:0]        op_set;
        logic [31:0]        spk_set;
        logic [18:0]        fwd_tmr;
        logic [18:0]        rev_tmr;
        logic [18:0]        op_tmr;
        logic               fwd_run;
        logic               rev_run;
        logic               op_run;
        logic               trip;
        logic               blk;
        logic [31:0]        fwd_cnt;
        logic [31:0]        rev_cnt;
        logic [31:0]        rdata;
    } ief_state_s;

    ief_state_s st_q;
    ief_state_s st_d;
    logic               tick;       // processing strobe
    logic signed [15:0] v_smp;      // selected voltage sample
    logic signed [15:0] i_smp;      // selected current sample
    logic               volt_ok;    // a voltage channel is chosen
    logic               pick;       // both peaks at or over threshold
    logic               dir_fwd;    // opposite polarity: faulty feeder
    logic               fwd_spk;
    logic               rev_spk;
    logic [2:0]         status;     // reported condition
    logic [1:0]         vch;        // reported voltage channel
    logic [31:0]        sp_rem;     // spikes still needed
    // magnitude without sign, saturating the most negative code
    function automatic logic [15:0] mag(input logic signed [15:0] x);
        logic [15:0] r;
        r = x[15] ? 16'(-x) : 16'(x);
        if (r[15]) begin
            r = 16'h7fff;
        end
        return r;
    endfunction
    // channel selection and derived decisions
    always_comb begin
        tick    = (st_q.tick_cnt == 32'(TICK_LEN - 1));
        // only voltage codes 1 and 2 are valid; any current code but 2 picks input one
        v_smp   = (st_q.volt_sel == 2'h2) ? samp_in.volt_four
                                          : samp_in.volt_three;
        volt_ok = (st_q.volt_sel == 2'h1) || (st_q.volt_sel == 2'h2);
        i_smp   = (st_q.in_sel == 2'h2) ? samp_in.cur_two
                                        : samp_in.cur_one;
        vch     = volt_ok ? st_q.volt_sel : 2'h0;
        // peak compared with the threshold is the ratio
        pick    = volt_ok && (mag(st_q.vpk) >= st_q.vthr)
                  && (mag(st_q.ipk) >= st_q.ithr);
        dir_fwd = (st_q.vpk[15] != st_q.ipk[15]);
        fwd_spk = tick && pick && dir_fwd && !block_in;
        rev_spk = tick && pick && !dir_fwd && !block_in;
        // computed condition, trip outranks start
        if (st_q.blk) begin
            status = STS_BLOCK;
        end else if (st_q.trip) begin
            status = STS_TRIP;
        end else if (st_q.fwd_run) begin
            status = STS_FWD;
        end else if (st_q.rev_run) begin
            status = STS_REV;
        end else begin
            status = STS_NORMAL;
        end
        // forcing remaps its own code order onto status codes
        if (st_q.force_en) begin
            unique case (st_q.force_code)
                FRC_NORMAL: status = status;
                FRC_BLOCK:  status = STS_BLOCK;
                FRC_FWD:    status = STS_FWD;
                FRC_REV:    status = STS_REV;
                FRC_TRIP:   status = STS_TRIP;
                default:    status = status;
            endcase
        end
        // trip needs the count to exceed the setting
        if (st_q.fwd_cnt > st_q.spk_set) begin
            sp_rem = 32'h0;
        end else begin
            sp_rem = st_q.spk_set - st_q.fwd_cnt + 32'h1;
        end
    end
    // next state: sampling, timing and register access
    always_comb begin
        st_d = st_q;
        st_d.tick_cnt = tick ? 32'h0 : st_q.tick_cnt + 32'h1;
        // peak capture over one buffer period
        if (tick) begin
            st_d.vpk = 16'sh0;
            st_d.ipk = 16'sh0;
        end
        if (samp_in.valid) begin
            if (tick || mag(v_smp) > mag(st_q.vpk)) begin
                st_d.vpk = v_smp;
            end
            if (tick || mag(i_smp) > mag(st_q.ipk)) begin
                st_d.ipk = i_smp;
            end
        end
        if (tick) begin
            st_d.blk = block_in;
            if (block_in) begin
                // blocking drops start and releases the timers
                st_d.fwd_run = 1'b0;
                st_d.rev_run = 1'b0;
                st_d.op_run  = 1'b0;
                st_d.trip    = 1'b0;
                st_d.fwd_cnt = 32'h0;
                st_d.rev_cnt = 32'h0;
            end else begin
                // forward release timer restarts on every spike
                if (fwd_spk) begin
                    st_d.fwd_run = 1'b1;
                    st_d.fwd_tmr = st_q.fwd_set;
                    st_d.fwd_cnt = st_q.fwd_cnt + 32'h1;
                end else if (st_q.fwd_run) begin
                    if (st_q.fwd_tmr == 19'h0) begin
                        // release clears the fault bookkeeping
                        st_d.fwd_run = 1'b0;
                        st_d.op_run  = 1'b0;
                        st_d.trip    = 1'b0;
                        st_d.fwd_cnt = 32'h0;
                    end else begin
                        st_d.fwd_tmr = st_q.fwd_tmr - 19'h1;
                    end
                end
                // reverse timer behaves alike
                if (rev_spk) begin
                    st_d.rev_run = 1'b1;
                    st_d.rev_tmr = st_q.rev_set;
                    st_d.rev_cnt = st_q.rev_cnt + 32'h1;
                end else if (st_q.rev_run) begin
                    if (st_q.rev_tmr == 19'h0) begin
                        st_d.rev_run = 1'b0;
                        st_d.rev_cnt = 32'h0;
                    end else begin
                        st_d.rev_tmr = st_q.rev_tmr - 19'h1;
                    end
                end
                // operating timer counts from the first strike
                if (fwd_spk && !st_q.fwd_run) begin
                    st_d.op_run = 1'b1;
                    st_d.op_tmr = st_q.op_set;
                end else if (st_q.op_run && st_d.fwd_run) begin
                    if (st_q.op_tmr != 19'h0) begin
                        st_d.op_tmr = st_q.op_tmr - 19'h1;
                    end else if (st_q.fwd_cnt > st_q.spk_set) begin
                        st_d.trip = 1'b1;
                    end
                end
                // a strike on the expiry tick still counts
                if (st_q.op_run && st_q.op_tmr == 19'h0 && st_d.fwd_run
                    && st_d.fwd_cnt > st_q.spk_set) begin
                    st_d.trip = 1'b1;
                end
            end
        end
        // settings are static: nothing but a write changes them
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                REG_CTRL: begin
                    st_d.force_en   = reg_wdata_in[CTRL_FEN_BIT];
                    st_d.force_code = reg_wdata_in[CTRL_FRC_LSB +: 3];
                    st_d.in_sel     = reg_wdata_in[CTRL_ISL_LSB +: 2];
                    st_d.volt_sel   = reg_wdata_in[CTRL_VSL_LSB +: 2];
                end
                REG_VTHR:   st_d.vthr    = reg_wdata_in[15:0];
                REG_ITHR:   st_d.ithr    = reg_wdata_in[15:0];
                REG_FWDRST: st_d.fwd_set = reg_wdata_in[18:0];
                REG_REVRST: st_d.rev_set = reg_wdata_in[18:0];
                REG_OPTIME: st_d.op_set  = reg_wdata_in[18:0];
                REG_SPIKES: st_d.spk_set = reg_wdata_in;
                default:    st_d.rdata   = st_d.rdata; // read-only
            endcase
        end
        // read data stands only in the cycle after the strobe
        st_d.rdata = 32'h0;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                REG_CTRL: begin
                    st_d.rdata[CTRL_FEN_BIT]      = st_q.force_en;
                    st_d.rdata[CTRL_FRC_LSB +: 3] = st_q.force_code;
                    st_d.rdata[CTRL_ISL_LSB +: 2] = st_q.in_sel;
                    st_d.rdata[CTRL_VSL_LSB +: 2] = st_q.volt_sel;
                end
                REG_VTHR:   st_d.rdata = {16'h0, st_q.vthr};
                REG_ITHR:   st_d.rdata = {16'h0, st_q.ithr};
                REG_FWDRST: st_d.rdata = {13'h0, st_q.fwd_set};
                REG_REVRST: st_d.rdata = {13'h0, st_q.rev_set};
                REG_OPTIME: st_d.rdata = {13'h0, st_q.op_set};
                REG_SPIKES: st_d.rdata = st_q.spk_set;
                REG_STATUS: begin
                    st_d.rdata[2:0]             = status;
                    st_d.rdata[STS_VCH_LSB +: 2] = vch;
                    st_d.rdata[STS_FWD_BIT]     = st_q.fwd_run;
                    st_d.rdata[STS_REV_BIT]     = st_q.rev_run;
                    st_d.rdata[STS_TRP_BIT]     = st_q.trip;
                    st_d.rdata[STS_BLK_BIT]     = st_q.blk;
                end
                REG_EXPT:   st_d.rdata = {13'h0, st_q.op_set};
                REG_TREM:   st_d.rdata = {13'h0, st_q.op_run ?
                                          st_q.op_tmr : st_q.op_set};
                REG_SPREM:  st_d.rdata = sp_rem;
                REG_FWDCNT: st_d.rdata = st_q.fwd_cnt;
                REG_REVCNT: st_d.rdata = st_q.rev_cnt;
                default:    st_d.rdata = 32'h0; // unmapped reads zero
            endcase
        end
    end
    // single state register, synchronous reset
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            st_q            <= '0;
            st_q.in_sel     <= ISEL_RST;
            st_q.volt_sel   <= VSEL_RST;
            st_q.vthr       <= VTHR_RST;
            st_q.ithr       <= ITHR_RST;
            st_q.fwd_set    <= FWDRST_RST;
            st_q.rev_set    <= REVRST_RST;
            st_q.op_set     <= OPTIME_RST;
            st_q.spk_set    <= SPIKES_RST;
        end else begin
            st_q <= st_d;
        end
    end
    // outputs follow the reported condition, so forcing reaches them
    always_comb begin
        reg_rdata_out     = st_q.rdata;
        forward_start_out = (status == STS_FWD);
        reverse_start_out = (status == STS_REV);
        trip_out          = (status == STS_TRIP);
        blocked_out       = (status == STS_BLOCK);
    end
    // assertions
    sequence s_fwd_spike;
        tick && fwd_spk;
    endsequence
    sequence s_released;
        !st_q.fwd_run && !st_q.op_run;
    endsequence
    property p_tick_period;
        @(posedge mclk_in) disable iff (rst_in)
        tick |=> !tick;
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("strobe lasted more than one cycle");
    property p_block_start;
        @(posedge mclk_in) disable iff (rst_in)
        (tick && block_in) |=> !st_q.fwd_run && !st_q.rev_run && st_q.blk;
    endproperty
    a_block_start: assert property (p_block_start)
        else $error("start survived blocking");
    property p_start_needs_pick;
        @(posedge mclk_in) disable iff (rst_in)
        $rose(st_q.fwd_run) |-> $past(pick) && !$past(block_in);
    endproperty
    a_start_needs_pick: assert property (p_start_needs_pick)
        else $error("forward start without pick-up");
    property p_reload;
        @(posedge mclk_in) disable iff (rst_in)
        s_fwd_spike |=> st_q.fwd_tmr == $past(st_q.fwd_set) && st_q.fwd_run;
    endproperty
    a_reload: assert property (p_reload)
        else $error("release timer not reloaded by spike");
    property p_release;
        @(posedge mclk_in) disable iff (rst_in)
        (tick && !block_in && !fwd_spk && st_q.fwd_run
         && st_q.fwd_tmr == 19'h0) |=> s_released;
    endproperty
    a_release: assert property (p_release)
        else $error("operating timer kept after release");
    property p_trip_count;
        @(posedge mclk_in) disable iff (rst_in)
        $rose(st_q.trip) |-> $past(st_q.fwd_cnt) > $past(st_q.spk_set)
                             || st_q.fwd_cnt > st_q.spk_set;
    endproperty
    a_trip_count: assert property (p_trip_count)
        else $error("trip with too few spikes");
    property p_vch;
        @(posedge mclk_in) disable iff (rst_in)
        !volt_ok |-> vch == 2'h0 && !pick;
    endproperty
    a_vch: assert property (p_vch)
        else $error("voltage channel reported without selection");
    property p_force;
        @(posedge mclk_in) disable iff (rst_in)
        (st_q.force_en && st_q.force_code == FRC_TRIP) |-> trip_out
            && !forward_start_out && !blocked_out;
    endproperty
    a_force: assert property (p_force)
        else $error("forced trip not shown");
    property p_read;
        @(posedge mclk_in) disable iff (rst_in)
        (reg_rd_in && reg_addr_in == REG_SPREM) |=>
            reg_rdata_out == $past(sp_rem);
    endproperty
    a_read: assert property (p_read)
        else $error("spikes remaining read wrong");
endmodule
`default_nettype wire

//--- sim/ief_samp_src.sv
`timescale 1ns/10ps
`default_nettype none
// stand-in for the residual measurement front end
module ief_samp_src (
    // clock and reset
    input  wire logic               mclk_in,
    input  wire logic               rst_in,
    // commanded amplitudes, signed, 0.01 per-unit steps
    input  wire logic signed [15:0] volt_amp_in,
    input  wire logic signed [15:0] cur1_amp_in,
    input  wire logic signed [15:0] cur2_amp_in,
    // sample stream towards the stage
    output var ief_pkg::ief_samp_s  samp_out
);
    import ief_pkg::*;
    // one valid sample per clock, so every 5 ms buffer holds plenty
    // the two current channels stay apart so a wrong pick shows up
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            samp_out <= '0;
        end else begin
            samp_out.valid      <= 1'b1;
            samp_out.volt_three <= volt_amp_in;
            samp_out.volt_four  <= volt_amp_in;
            samp_out.cur_one    <= cur1_amp_in;
            samp_out.cur_two    <= cur2_amp_in;
        end
    end
endmodule
`default_nettype wire

//--- sim/ief_stage_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ief_stage_tb;
    import ief_pkg::*;
    // short tick keeps the run small; every wait derives from it
    localparam int unsigned TL = 20;
    logic               mclk_in = 1'b0;  // bench clock
    logic               rst_in  = 1'b1;  // sync reset
    logic        [3:0]  reg_addr_in = '0;
    logic        [31:0] reg_wdata_in = '0;
    logic               reg_wr_in = 1'b0;
    logic               reg_rd_in = 1'b0;
    logic        [31:0] reg_rdata_out;
    ief_samp_s          samp;            // partner to stage
    logic               block_in = 1'b0;
    logic               fwd, rev, trp, blk;
    logic signed [15:0] va = '0, ia = '0, ib = '0;
    int                 num_errors = 0;
    int                 check_count = 0;
    int                 seed = 55;
    logic        [31:0] d;
    int                 k;

    always #5 mclk_in = ~mclk_in;

    ief_samp_src src_u (.mclk_in(mclk_in), .rst_in(rst_in),
        .volt_amp_in(va), .cur1_amp_in(ia), .cur2_amp_in(ib),
        .samp_out(samp));
    ief_stage #(.TICK_LEN(TL)) dut_u (.mclk_in(mclk_in),
        .rst_in(rst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .samp_in(samp), .block_in(block_in),
        .forward_start_out(fwd), .reverse_start_out(rev),
        .trip_out(trp), .blocked_out(blk));

    // expected start: both peaks at or over threshold
    function automatic logic exp_pick(int v, int i, int vt, int it);
        return ((v < 0 ? -v : v) >= vt) && ((i < 0 ? -i : i) >= it);
    endfunction
    // opposite peak signs mean the faulty feeder, i.e. forward
    function automatic logic exp_fwd(int v, int i);
        return (v < 0) != (i < 0);
    endfunction
    function automatic logic pin(int sel);
        case (sel)
            0: return fwd;
            1: return rev;
            2: return trp;
            default: return blk;
        endcase
    endfunction

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // one-cycle strobes; read data taken at the edge closing its cycle,
    // so every task ends on a rising edge and stimulus stays edge aligned
    task automatic wr(logic [3:0] a, logic [31:0] v);
        @(posedge mclk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= v;
        reg_wr_in    <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, output logic [31:0] v);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        @(posedge mclk_in);
        v = reg_rdata_out;
    endtask
    // bounded wait on an output pin; running out ends the run
    task automatic wait_pin(int sel, logic lvl, int lim);
        int n;
        n = 0;
        while (pin(sel) !== lvl && n < lim) begin
            @(posedge mclk_in);
            n++;
        end
        if (pin(sel) !== lvl) begin
            num_errors++;
            $display("mismatch pin %0d exp %b seen %b", sel, lvl, pin(sel));
            wrap_up();
        end
    endtask
    task automatic drive(int v, int i1, int i2);
        @(posedge mclk_in);
        va <= 16'(v);
        ia <= 16'(i1);
        ib <= 16'(i2);
    endtask
    task automatic reset_dut();
        drive(0, 0, 0);
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
    endtask
    task automatic quiet(int n);
        repeat (n * TL) @(posedge mclk_in);
    endtask

    initial begin
        logic [3:0]  ad [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                                 4'h6, 4'h8, 4'h7, 4'hf};
        logic [31:0] ex [10] = '{32'h50, 32'h1f40, 32'h32, 32'h3c, 32'h3c,
                                 32'h64, 32'h2, 32'h64, 32'h10, 32'h0};
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        // register defaults, including an unmapped index
        for (k = 0; k < 10; k++) begin
            rd(ad[k], d);
            check("reset value", d, ex[k]);
        end
        rd(REG_SPREM, d);
        check("spikes left idle", d, 32'h3);
        rd(REG_TREM, d);
        check("time left idle", d, 32'h64);
        $display("test defaults done");
        // forward fault with short timers runs into trip
        wr(REG_FWDRST, 32'h3);
        wr(REG_OPTIME, 32'h4);
        wr(REG_SPIKES, 32'h1);
        k = 8000 + ($random(seed) & 32'hfff);
        drive(k, -k, 0);
        wait_pin(0, exp_fwd(k, -k), 3 * TL);
        rd(REG_STATUS, d);
        check("status fwd", 32'(d[2:0]), 32'(STS_FWD));
        rd(REG_TREM, d);
        check("time left", d, 32'h4);
        rd(REG_SPREM, d);
        check("spikes left", d, 32'h1);
        rd(REG_FWDCNT, d);
        check("fwd count", d, 32'h1);
        wait_pin(2, 1'b1, 8 * TL);
        rd(REG_STATUS, d);
        check("status trip", 32'(d[2:0]), 32'(STS_TRIP));
        drive(0, 0, 0);
        wait_pin(2, 1'b0, 8 * TL);
        check("fwd released", 32'(fwd), 32'h0);
        $display("test forward trip done");
        // same signs: reverse start only
        reset_dut();
        drive(9000, 600, 0);
        wait_pin(1, 1'b1, 3 * TL);
        check("no fwd on rev", 32'(fwd), 32'(exp_fwd(9000, 600)));
        rd(REG_REVCNT, d);
        check("rev count", d, 32'h1);
        // default reverse release time is 60 ticks, so allow 70
        drive(0, 0, 0);
        wait_pin(1, 1'b0, 70 * TL);
        rd(REG_REVCNT, d);
        check("rev count cleared", d, 32'h0);
        $display("test reverse done");
        // random sub-threshold pairs never start
        for (k = 0; k < 4; k++) begin
            reset_dut();
            d = 32'($unsigned($random(seed)) % 7999);
            if (k[0]) begin
                drive(d, -60, 0);
            end else begin
                drive(9000, -(d % 50), 0);
            end
            quiet(3);
            check("below pick", 32'(fwd | rev), 32'(exp_pick(
                k[0] ? d : 9000, k[0] ? 60 : d % 50,
                VTHR_RST, ITHR_RST)));
        end
        $display("test thresholds done");
        // second current input only counts once selected
        reset_dut();
        drive(9000, 0, -900);
        quiet(3);
        check("unselected chan", 32'(fwd), 32'h0);
        wr(REG_CTRL, 32'h60);
        wait_pin(0, 1'b1, 3 * TL);
        $display("test input select done");
        // voltage channel report and no start without voltage
        reset_dut();
        wr(REG_CTRL, 32'h90);
        rd(REG_STATUS, d);
        check("volt chan four", 32'(d[5:4]), 32'h2);
        wr(REG_CTRL, 32'h10);
        rd(REG_STATUS, d);
        check("volt chan none", 32'(d[5:4]), 32'h0);
        drive(9000, -900, 0);
        quiet(3);
        check("no volt no start", 32'(fwd), 32'h0);
        $display("test volt channel done");
        // blocking wins over a pick, start follows once lifted
        reset_dut();
        block_in <= 1'b1;
        drive(9000, -900, 0);
        wait_pin(3, 1'b1, 3 * TL);
        check("blocked no start", 32'(fwd), 32'h0);
        rd(REG_STATUS, d);
        check("status blocked", 32'(d[2:0]), 32'(STS_BLOCK));
        block_in <= 1'b0;
        wait_pin(0, 1'b1, 3 * TL);
        $display("test blocking done");
        // every forcing code, then a code with forcing off
        reset_dut();
        // code 0 with forcing on must leave the computed (normal) state
        for (k = 0; k < 5; k++) begin
            wr(REG_CTRL, 32'h51 | (k << 1));
            @(posedge mclk_in);
            check("forced pins", {28'h0, fwd, rev, trp, blk},
                  (k == 0) ? 32'h0 : (k == 1) ? 32'h1 :
                  (k == 2) ? 32'h8 : (k == 3) ? 32'h4 : 32'h2);
        end
        wr(REG_CTRL, 32'h54);
        @(posedge mclk_in);
        check("force off", {28'h0, fwd, rev, trp, blk}, 32'h0);
        $display("test forcing done");
        // recommended settings; 7000 starts only once 6000 is written
        reset_dut();
        wr(REG_VTHR, 32'h1770);
        wr(REG_FWDRST, 32'h5a);
        wr(REG_REVRST, 32'h32);
        wr(REG_OPTIME, 32'h64);
        drive(7000, -60, 0);
        wait_pin(0, 1'b1, 3 * TL);
        wait_pin(2, 1'b1, 110 * TL);
        rd(REG_FWDCNT, d);
        check("spikes over two", 32'(d > 32'h2), 32'h1);
        $display("test recommended done");
        wrap_up();
    end
endmodule
`default_nettype wire
